// ### design/bpm_cfg.svh
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH

// free-running clock period in ns
`define BPM_CLK_PERIOD_NS 10
// driver enable delay in save mode, microseconds
`define BPM_ENABLE_DELAY_US 10
`define BPM_ENABLE_DELAY_CYC ((`BPM_ENABLE_DELAY_US * 1000 + `BPM_CLK_PERIOD_NS - 1) / `BPM_CLK_PERIOD_NS)
// low-side inactivity timeout, microseconds (typical figure)
`define BPM_ACT_TIMEOUT_US 100
`define BPM_ACT_TIMEOUT_CYC ((`BPM_ACT_TIMEOUT_US * 1000) / `BPM_CLK_PERIOD_NS)
`define BPM_TIMER_W 16

`endif

// ### design/bpm_pkg.sv
package bpm_pkg;
    typedef enum logic [1:0] {
        BPM_STARTUP = 2'b00,
        BPM_SAVE = 2'b01,
        BPM_OPER = 2'b10,
        BPM_SHUTDOWN = 2'b11
    } bpm_mode_t;
endpackage

// ### design/bpm_sequencer.sv
// Behaviour
// - start-up: generator on, reference off with clamp, regulator/guard/drivers disabled
// - supply reaches turn-on level: generator off, go to save
// - save without low-side activity: cycle generator between turn-on and save-low levels
// - save: reference low-current only; regulator, guard and drivers disabled
// - save: supply below reference-off level returns to start-up
// - operate only on high-side command fall after enable delay, reference above 3.0V
// - operating: generator off, reference high current, regulator, guard and drivers enabled
// - no low-side activity beyond the timeout returns operating to save
// - operating: supply below turn-off or reference undervoltage enters shut-down
// - shut-down: generator on, reference low current, everything else disabled
// - shut-down: turn-on level to save, below reference-off to start-up
// - overcurrent guard runs in parallel, active only in operating mode
// - sense trip latches fault: gates low, flag high, cleared when inputs low
// - both gate commands high force both half-bridge outputs low
// - regulator switch: close above top, band closes and low opens on low-side fall
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_sequencer #(
    parameter int ENABLE_DELAY_CYC = `BPM_ENABLE_DELAY_CYC,
    parameter int ACT_TIMEOUT_CYC = `BPM_ACT_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic supply_above_on,
    input wire logic supply_above_save_low,
    input wire logic supply_above_off,
    input wire logic supply_above_ref_off,
    input wire logic ref_above_enable,
    input wire logic ref_above_uv,
    input wire logic supply_above_reg_top,
    input wire logic supply_above_reg_on,
    input wire logic supply_above_reg_off,
    input wire logic sense_trip,
    input wire logic high_side_gate_cmd,
    input wire logic low_side_gate_cmd,
    output logic hv_startup_gen,
    output logic ref_enable,
    output logic ref_high_current,
    output logic ref_sink_clamp,
    output logic two_point_supply_reg,
    output logic regulator_switch,
    output logic overcurrent_guard,
    output logic drivers_enable,
    output logic high_side_gate_out,
    output logic low_side_gate_out,
    output logic fault_flag_out,
    output bpm_pkg::bpm_mode_t mode
);
    import bpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; stage one is read only by stage two
    localparam int NS = 13;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] sy1_ff;
    logic [NS-1:0] sy2_ff;
    logic [NS-1:0] nxt_sy1;
    logic [NS-1:0] nxt_sy2;
    logic hs_prev_ff;
    logic ls_prev_ff;
    logic nxt_hs_prev;
    logic nxt_ls_prev;

    assign raw_in = {supply_above_on, supply_above_save_low, supply_above_off, supply_above_ref_off,
                     ref_above_enable, ref_above_uv, supply_above_reg_top, supply_above_reg_on,
                     supply_above_reg_off, sense_trip, high_side_gate_cmd, low_side_gate_cmd, 1'b0};

    always_comb begin
        nxt_sy1 = raw_in;
        nxt_sy2 = sy1_ff;
        nxt_hs_prev = sy2_ff[2];
        nxt_ls_prev = sy2_ff[1];
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
            hs_prev_ff <= 1'b0;
            ls_prev_ff <= 1'b0;
        end else begin
            sy1_ff <= nxt_sy1;
            sy2_ff <= nxt_sy2;
            hs_prev_ff <= nxt_hs_prev;
            ls_prev_ff <= nxt_ls_prev;
        end
    end

    logic s_on, s_save_low, s_off, s_ref_off, s_ref_en, s_ref_uv, s_top, s_reg_on, s_reg_off, s_trip, s_hs, s_ls;
    assign s_on = sy2_ff[12];
    assign s_save_low = sy2_ff[11];
    assign s_off = sy2_ff[10];
    assign s_ref_off = sy2_ff[9];
    assign s_ref_en = sy2_ff[8];
    assign s_ref_uv = sy2_ff[7];
    assign s_top = sy2_ff[6];
    assign s_reg_on = sy2_ff[5];
    assign s_reg_off = sy2_ff[4];
    assign s_trip = sy2_ff[3];
    assign s_hs = sy2_ff[2];
    assign s_ls = sy2_ff[1];

    logic hs_fall;
    logic ls_fall;
    logic ls_edge;
    assign hs_fall = hs_prev_ff & ~s_hs;
    assign ls_fall = ls_prev_ff & ~s_ls;
    assign ls_edge = ls_prev_ff ^ s_ls;

    ////////////////////////////////////////////////////////////////////////////////
    // mode machine with delay and inactivity timers
    bpm_mode_t mode_ff;
    bpm_mode_t nxt_mode;
    logic [`BPM_TIMER_W-1:0] dly_ff;
    logic [`BPM_TIMER_W-1:0] nxt_dly;
    logic [`BPM_TIMER_W-1:0] idle_ff;
    logic [`BPM_TIMER_W-1:0] nxt_idle;
    logic hv_ff;
    logic nxt_hv;
    logic dly_done;
    logic idle_expired;

    assign dly_done = dly_ff >= `BPM_TIMER_W'(ENABLE_DELAY_CYC);
    assign idle_expired = idle_ff >= `BPM_TIMER_W'(ACT_TIMEOUT_CYC);

    always_comb begin
        nxt_mode = mode_ff;
        nxt_hv = hv_ff;
        nxt_dly = '0;
        nxt_idle = '0;
        unique case (mode_ff)
            BPM_STARTUP: begin
                nxt_hv = 1'b1;
                if (s_on) begin
                    nxt_hv = 1'b0;
                    nxt_mode = BPM_SAVE;
                end
            end
            BPM_SAVE: begin
                // counter saturates so a long wait cannot wrap back below the delay
                nxt_dly = dly_done ? dly_ff : dly_ff + 1'b1;
                nxt_idle = ls_edge ? '0 : (idle_expired ? idle_ff : idle_ff + 1'b1);
                // hysteresis on the generator while the controller is quiet
                if (!ls_edge && idle_expired) begin
                    if (s_on) begin
                        nxt_hv = 1'b0;
                    end else if (!s_save_low) begin
                        nxt_hv = 1'b1;
                    end
                end else if (s_on) begin
                    nxt_hv = 1'b0;
                end
                if (!s_ref_off) begin
                    nxt_mode = BPM_STARTUP;
                    nxt_hv = 1'b1;
                end else if (hs_fall && dly_done && s_ref_en) begin
                    nxt_mode = BPM_OPER;
                    nxt_hv = 1'b0;
                    // the save-mode idle count may be saturated by now; carried over it would end operation at once
                    nxt_idle = '0;
                end
            end
            BPM_OPER: begin
                nxt_hv = 1'b0;
                nxt_idle = ls_edge ? '0 : idle_ff + 1'b1;
                if (!s_off || !s_ref_uv) begin
                    nxt_mode = BPM_SHUTDOWN;
                    nxt_hv = 1'b1;
                end else if (idle_expired) begin
                    nxt_mode = BPM_SAVE;
                end
            end
            BPM_SHUTDOWN: begin
                nxt_hv = 1'b1;
                if (!s_ref_off) begin
                    nxt_mode = BPM_STARTUP;
                end else if (s_on) begin
                    nxt_mode = BPM_SAVE;
                    nxt_hv = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= BPM_STARTUP;
            hv_ff <= 1'b1;
            dly_ff <= '0;
            idle_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            hv_ff <= nxt_hv;
            dly_ff <= nxt_dly;
            idle_ff <= nxt_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // overcurrent latch and regulator switch
    logic fault_ff;
    logic nxt_fault;
    logic psw_ff;
    logic nxt_psw;
    logic oper;
    assign oper = (mode_ff == BPM_OPER);

    always_comb begin
        nxt_fault = fault_ff;
        if (!oper) begin
            nxt_fault = 1'b0;
        end else if (s_trip) begin
            nxt_fault = 1'b1;
        end else if (!s_hs && !s_ls) begin
            nxt_fault = 1'b0;
        end
        nxt_psw = psw_ff;
        if (!oper) begin
            nxt_psw = 1'b0;
        end else if (s_top) begin
            nxt_psw = 1'b1;
        end else if (ls_fall) begin
            if (!s_reg_off) begin
                nxt_psw = 1'b0;
            end else if (s_reg_on) begin
                nxt_psw = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_ff <= 1'b0;
            psw_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
            psw_ff <= nxt_psw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; gate outputs from flops on synchronised commands
    logic hsg_ff;
    logic lsg_ff;
    logic nxt_hsg;
    logic nxt_lsg;
    logic gate_ok;

    // fault and mode veto on their next values, the interlock on the current synchronised commands, so the gates never lag a mode exit by a cycle
    assign gate_ok = (nxt_mode == BPM_OPER) && !nxt_fault && !(s_hs && s_ls);

    always_comb begin
        nxt_hsg = gate_ok & s_hs;
        nxt_lsg = gate_ok & s_ls;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hsg_ff <= 1'b0;
            lsg_ff <= 1'b0;
        end else begin
            hsg_ff <= nxt_hsg;
            lsg_ff <= nxt_lsg;
        end
    end

    assign hv_startup_gen = hv_ff;
    assign ref_enable = (mode_ff != BPM_STARTUP);
    assign ref_high_current = oper;
    assign ref_sink_clamp = (mode_ff == BPM_STARTUP);
    assign two_point_supply_reg = oper;
    assign regulator_switch = psw_ff;
    assign overcurrent_guard = oper;
    assign drivers_enable = oper;
    assign high_side_gate_out = hsg_ff;
    assign low_side_gate_out = lsg_ff;
    assign fault_flag_out = fault_ff;
    assign mode = mode_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_startup_outputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_STARTUP |-> hv_startup_gen && ref_sink_clamp && !ref_enable && !drivers_enable)
        else $error("start-up outputs wrong");
    a_startup_leave: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_STARTUP && s_on |=> mode_ff == BPM_SAVE && !hv_startup_gen)
        else $error("start-up did not leave");
    a_save_gen_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SAVE && s_ref_off && !s_save_low && !s_on && idle_expired && !ls_edge && !hs_fall
        |=> hv_startup_gen)
        else $error("save generator not on");
    a_save_outputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SAVE |-> ref_enable && !ref_high_current && !two_point_supply_reg && !low_side_gate_out)
        else $error("save outputs wrong");
    a_save_to_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SAVE && !s_ref_off |=> mode_ff == BPM_STARTUP)
        else $error("save did not drop");
    a_oper_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SAVE && $past(mode_ff) == BPM_SAVE ##1 mode_ff == BPM_OPER
        |-> $past(hs_fall) && $past(dly_done) && $past(s_ref_en))
        else $error("bad operating entry");
    a_oper_outputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_OPER |-> !hv_startup_gen && ref_high_current && overcurrent_guard && drivers_enable)
        else $error("operating outputs wrong");
    a_oper_timeout: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_OPER && idle_expired && s_off && s_ref_uv |=> mode_ff == BPM_SAVE)
        else $error("timeout ignored");
    a_oper_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_OPER && !s_off |=> mode_ff == BPM_SHUTDOWN ##1 hv_startup_gen)
        else $error("shut-down missed");
    a_shut_outputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SHUTDOWN |-> hv_startup_gen && ref_enable && !ref_high_current && !drivers_enable)
        else $error("shut-down outputs wrong");
    a_fault_gates: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fault_ff |-> !high_side_gate_out && !low_side_gate_out)
        else $error("gate on during fault");
    a_interlock: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hs && s_ls |=> !high_side_gate_out && !low_side_gate_out)
        else $error("cross conduction");
    a_guard_only_oper: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff != BPM_OPER |=> !fault_flag_out || $past(mode_ff) == BPM_OPER)
        else $error("fault outside operating");
    a_shut_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff == BPM_SHUTDOWN && !s_ref_off |=> mode_ff == BPM_STARTUP)
        else $error("shut-down did not drop");
    a_psw_only_oper: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_ff != BPM_OPER |=> !regulator_switch)
        else $error("switch closed outside operating");
endmodule

// ### dv/bpm_mcu_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module bpm_mcu_model #(
    parameter int LS_HALF = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hs_req,
    input wire logic ls_req,
    input wire logic ls_run,
    output logic high_side_gate_cmd,
    output logic low_side_gate_cmd
);
    int cnt_ff;
    // requests are sampled on the rising edge, clear of the bench's falling-edge updates;
    // non-blocking updates let the device see the previous level at that same edge
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 0;
            high_side_gate_cmd <= 1'b0;
            low_side_gate_cmd <= 1'b0;
        end else begin
            high_side_gate_cmd <= hs_req;
            if (!ls_run) begin
                cnt_ff <= 0;
                low_side_gate_cmd <= ls_req;
            end else if (cnt_ff == LS_HALF - 1) begin
                cnt_ff <= 0;
                low_side_gate_cmd <= !low_side_gate_cmd;
            end else begin
                cnt_ff <= cnt_ff + 1;
            end
        end
    end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    import bpm_pkg::*;
    localparam int ED = 20;
    localparam int TO = 50;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic supply_above_on, supply_above_save_low, supply_above_off, supply_above_ref_off, ref_above_enable;
    logic ref_above_uv, supply_above_reg_top, supply_above_reg_on, supply_above_reg_off, sense_trip;
    logic hs_req, ls_req, ls_run, high_side_gate_cmd, low_side_gate_cmd;
    logic hv_startup_gen, ref_enable, ref_high_current, ref_sink_clamp, two_point_supply_reg, regulator_switch;
    logic overcurrent_guard, drivers_enable, high_side_gate_out, low_side_gate_out, fault_flag_out;
    bpm_mode_t mode;
    int failures = 0;
    int check_count = 0;
    always #5 sys_clk = ~sys_clk;
    bpm_mcu_model #(.LS_HALF(8)) bpm_mcu_model_i (.sys_clk, .reset_n, .hs_req, .ls_req, .ls_run,
        .high_side_gate_cmd, .low_side_gate_cmd);
    bpm_sequencer #(.ENABLE_DELAY_CYC(ED), .ACT_TIMEOUT_CYC(TO)) bpm_sequencer_i (.sys_clk, .reset_n,
        .supply_above_on, .supply_above_save_low, .supply_above_off, .supply_above_ref_off, .ref_above_enable,
        .ref_above_uv, .supply_above_reg_top, .supply_above_reg_on, .supply_above_reg_off, .sense_trip,
        .high_side_gate_cmd, .low_side_gate_cmd, .hv_startup_gen, .ref_enable, .ref_high_current, .ref_sink_clamp,
        .two_point_supply_reg, .regulator_switch, .overcurrent_guard, .drivers_enable, .high_side_gate_out,
        .low_side_gate_out, .fault_flag_out, .mode);
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] outs();
        return {hv_startup_gen, ref_enable, ref_high_current, ref_sink_clamp, two_point_supply_reg,
            overcurrent_guard, drivers_enable};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // bounded wait; the caller judges the mode afterwards
    task automatic wm(input bpm_mode_t m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) @(negedge sys_clk);
    endtask
    task automatic go_oper();
        hs_req = 1'b1;
        cyc(ED + 6);
        hs_req = 1'b0;
        ls_run = 1'b1;
        wm(BPM_OPER, 8);
    endtask
    task automatic wrap_up();
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(outs(), 7'h48)
        reset_n = 1'b1;
        cyc(10);
        `CHK(mode, BPM_STARTUP)
        `CHK(outs(), 7'h48)
    endtask
    task automatic t_save();
        hs_req = 1'b1;
        supply_above_on = 1'b1;
        supply_above_save_low = 1'b1;
        wm(BPM_SAVE, 6);
        `CHK(mode, BPM_SAVE)
        `CHK(outs(), 7'h20)
        hs_req = 1'b0;
        sense_trip = 1'b1;
        cyc(ED - 6);
        `CHK(mode, BPM_SAVE)
        `CHK({fault_flag_out, regulator_switch}, 2'b00)
        sense_trip = 1'b0;
        supply_above_on = 1'b0;
        supply_above_save_low = 1'b0;
        cyc(TO + 10);
        `CHK(hv_startup_gen, 1'b1)
        supply_above_on = 1'b1;
        supply_above_save_low = 1'b1;
        cyc(5);
        `CHK(hv_startup_gen, 1'b0)
        ref_above_enable = 1'b0;
        hs_req = 1'b1;
        cyc(3);
        hs_req = 1'b0;
        cyc(6);
        `CHK(mode, BPM_SAVE)
        ref_above_enable = 1'b1;
        go_oper();
        `CHK(mode, BPM_OPER)
        `CHK(outs(), 7'h37)
    endtask
    // gate commands held still for short spells, well inside the activity timeout
    task automatic t_gates();
        ls_req = 1'b1;
        ls_run = 1'b0;
        cyc(4);
        `CHK({high_side_gate_out, low_side_gate_out}, 2'b01)
        hs_req = 1'b1;
        cyc(4);
        `CHK({high_side_gate_out, low_side_gate_out}, 2'b00)
        hs_req = 1'b0;
        cyc(4);
        `CHK({high_side_gate_out, low_side_gate_out}, 2'b01)
        sense_trip = 1'b1;
        cyc(4);
        `CHK({fault_flag_out, high_side_gate_out, low_side_gate_out}, 3'b100)
        sense_trip = 1'b0;
        cyc(4);
        `CHK(fault_flag_out, 1'b1)
        ls_req = 1'b0;
        cyc(4);
        `CHK(fault_flag_out, 1'b0)
        ls_run = 1'b1;
    endtask
    task automatic t_reg();
        {supply_above_reg_top, supply_above_reg_on, supply_above_reg_off} = 3'h7;
        cyc(4);
        `CHK(regulator_switch, 1'b1)
        {supply_above_reg_top, supply_above_reg_on, supply_above_reg_off} = 3'h0;
        cyc(20);
        `CHK(regulator_switch, 1'b0)
        {supply_above_reg_on, supply_above_reg_off} = 2'h3;
        cyc(20);
        `CHK(regulator_switch, 1'b1)
    endtask
    task automatic t_timeout();
        ls_run = 1'b0;
        cyc(TO - 15);
        `CHK(mode, BPM_OPER)
        wm(BPM_SAVE, 30);
        `CHK(mode, BPM_SAVE)
    endtask
    task automatic t_faults();
        go_oper();
        supply_above_on = 1'b0;
        supply_above_off = 1'b0;
        wm(BPM_SHUTDOWN, 6);
        `CHK(mode, BPM_SHUTDOWN)
        `CHK(outs(), 7'h60)
        supply_above_off = 1'b1;
        supply_above_on = 1'b1;
        wm(BPM_SAVE, 6);
        `CHK(mode, BPM_SAVE)
        supply_above_ref_off = 1'b0;
        wm(BPM_STARTUP, 6);
        `CHK(outs(), 7'h48)
        supply_above_ref_off = 1'b1;
        wm(BPM_SAVE, 6);
        go_oper();
        supply_above_on = 1'b0;
        ref_above_uv = 1'b0;
        wm(BPM_SHUTDOWN, 6);
        `CHK(mode, BPM_SHUTDOWN)
        supply_above_ref_off = 1'b0;
        wm(BPM_STARTUP, 6);
        `CHK(mode, BPM_STARTUP)
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        {supply_above_on, supply_above_save_low, supply_above_reg_top, supply_above_reg_on} = 4'h0;
        {supply_above_reg_off, sense_trip, hs_req, ls_req, ls_run} = 5'h00;
        {supply_above_off, supply_above_ref_off, ref_above_enable, ref_above_uv} = 4'hF;
        cyc(16);
        t_reset();
        t_save();
        t_gates();
        t_reg();
        t_timeout();
        t_faults();
        wrap_up();
    end
    initial begin
        // several times the few hundred cycles the scenarios need
        #20000;
        failures++;
        wrap_up();
    end
endmodule
